// ===== bench/eic_host_model.sv
// Host model that sends framed parameter writes
module eic_host_model
    import eic_pkg::*;
(
    input  wire logic        clock,      // Clock
    input  wire logic        rsp_valid,  // Answer pulse
    input  wire logic [15:0] rsp_end,    // End code
    output logic             wr_valid,   // Frame strobe
    output logic [15:0]      wr_code,    // Command code
    output logic [15:0]      wr_addr,    // Data number field
    output logic [15:0]      wr_unit_ch, // Unit and channel
    output logic [15:0]      wr_count,   // Element count
    output logic [31:0]      wr_data     // Value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_end; // End code of the last answer
    logic        got_rsp;  // Answer seen in its cycle
    initial
    begin
        wr_valid = 1'b0;
        {wr_code, wr_addr, wr_unit_ch, wr_count, wr_data} = '0;
    end
    // One frame over one edge; fields scrambled once released
    task automatic send(input logic [15:0] code, addr, uc, cnt,
                        input logic [31:0] data);
        @(negedge clock);
        {wr_code, wr_addr, wr_unit_ch, wr_count} = {code, addr, uc, cnt};
        wr_data  = data;
        wr_valid = 1'b1;
        @(negedge clock);
        wr_valid = 1'b0;
        {wr_code, wr_addr, wr_unit_ch, wr_count, wr_data} =
            ~{wr_code, wr_addr, wr_unit_ch, wr_count, wr_data};
        got_rsp  = rsp_valid;
        last_end = rsp_end;
    endtask : send
    // Well formed one element write to a unit and data number
    task automatic put(input logic [7:0] unit, dn, input logic [31:0] d);
        send(EIC_WRITE_CODE, {EIC_ADDR_PREFIX, dn}, {unit, 8'h01},
             EIC_ONE_ELEMENT, d);
    endtask : put
endmodule : eic_host_model

// ===== bench/eic_props.sv
// Port checks for the external input command block
module eic_props
    import eic_pkg::*;
(
    input wire logic        clock,            // Clock
    input wire logic        reset,            // Async reset
    input wire logic        wr_valid,         // Frame strobe
    input wire logic [15:0] wr_code,          // Command code
    input wire logic [15:0] wr_addr,          // Data number field
    input wire logic [15:0] wr_unit_ch,       // Unit and channel
    input wire logic [15:0] wr_count,         // Element count
    input wire logic [31:0] wr_data,          // Value
    input wire logic [EIC_LINES-1:0] pin_inputs, // Lines
    input wire logic        rsp_valid,        // Answer pulse
    input wire logic [15:0] rsp_code,         // Echoed code
    input wire logic [15:0] rsp_end,          // End code
    input wire logic        timing_active,    // Timing input
    input wire logic        reset_active,     // Reset input
    input wire logic        zero_reset_pulse, // Zero reset
    input wire logic        bank_mode,        // Bank mode
    input wire logic        focus_mode_on     // Focus mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       std_h; // Standard mode as seen from writes
    logic [3:0] quiet; // Steady pin cycles in standard mode
    // Frame decode
    wire        good = wr_valid && wr_code == EIC_WRITE_CODE
                    && wr_count == EIC_ONE_ELEMENT
                    && wr_addr[15:8] == EIC_ADDR_PREFIX;
    wire [7:0]  unit = wr_unit_ch[15:8];
    wire [7:0]  dn   = wr_addr[7:0];
    wire        sys  = good && unit == EIC_UNIT_SYSTEM;
    wire        on1  = wr_data == EIC_VAL_ON;
    wire        mw   = sys && dn == EIC_DN_EXT_MODE;
    // Mode copy and steady span counter
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            std_h <= 1'b1;
            quiet <= 4'h0;
        end
        else
        begin
            if (mw && (wr_data == EIC_MODE_STANDARD
                       || wr_data == EIC_MODE_PAR_OFF))
                std_h <= wr_data == EIC_MODE_STANDARD;
            if (!std_h || !$stable(pin_inputs))
                quiet <= 4'h0;
            else if (quiet != 4'hf)
                quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_answer_next: assert property (wr_valid |=> rsp_valid)
        else $error("answer missing after frame");
    a_code_echo: assert property (
        wr_valid |=> rsp_code == $past(wr_code))
        else $error("answer code not echoed");
    a_bad_frame: assert property (
        wr_valid && !good |=> rsp_end == EIC_END_ERROR)
        else $error("bad frame not refused");
    a_std_refuse: assert property (
        sys && std_h && dn >= EIC_DN_TIMING && dn <= EIC_DN_ZERO_CANCEL
        |=> rsp_end == EIC_END_ERROR)
        else $error("input command taken in standard mode");
    a_exec_pulse: assert property (
        sys && !std_h && on1 && dn == EIC_DN_ZERO_EXECUTE
        |=> zero_reset_pulse)
        else $error("zero reset pulse missing");
    a_timing_hold: assert property (
        sys && !std_h && on1 && dn == EIC_DN_TIMING
        |=> ##1 timing_active[*2])
        else $error("timing command not held");
    a_bank_lock: assert property (
        good && unit == EIC_UNIT_INPUTS && bank_mode && dn[7:1] == 7'h05
        && !$past(wr_valid) |=> rsp_end == EIC_END_ERROR)
        else $error("bank input mode change taken");
    a_focus_lock: assert property (
        good && unit == EIC_UNIT_FOCUS && !focus_mode_on && !$past(wr_valid)
        && dn >= EIC_DN_FOCUS_FIRST && dn <= EIC_DN_FOCUS_LAST
        |=> rsp_end == EIC_END_ERROR)
        else $error("focus value taken with mode off");
    a_pins_follow: assert property (
        quiet == 4'hf |-> timing_active == pin_inputs[0]
        && reset_active == pin_inputs[1])
        else $error("outputs do not follow pins");
endmodule : eic_props

// ===== bench/tb.sv
// Self-checking testbench for the external input command block
module tb
    import eic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] OK = EIC_END_NORMAL;
    localparam logic [15:0] ER = EIC_END_ERROR;
    logic        clock = 1'b0, reset = 1'b1, wr_valid, rsp_valid;
    logic [15:0] wr_code, wr_addr, wr_unit_ch, wr_count, rsp_code, rsp_end;
    logic [31:0] wr_data, focus_rd_data;
    logic [4:0]  pin_inputs = 5'h00;
    logic [2:0]  focus_rd_index = 3'h0;
    logic        timing_active, reset_active, laser_off_active;
    logic        zero_reset_pulse, zero_cancel_pulse, bank_mode, focus_mode_on;
    logic [11:0] input_modes;
    int          n_mismatch = 0, comparisons = 0;
    always #2.5 clock = ~clock;
    eic_external_input_command_control dut (.clock, .reset, .wr_valid,
        .wr_code, .wr_addr, .wr_unit_ch, .wr_count, .wr_data, .pin_inputs,
        .focus_rd_index, .rsp_valid, .rsp_code, .rsp_end, .timing_active,
        .reset_active, .laser_off_active, .zero_reset_pulse,
        .zero_cancel_pulse, .bank_mode, .focus_mode_on, .input_modes,
        .focus_rd_data);
    eic_host_model host (.clock, .rsp_valid, .rsp_end, .wr_valid, .wr_code,
        .wr_addr, .wr_unit_ch, .wr_count, .wr_data);
    // Compare a value
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Compare the answer of the last frame
    task automatic chk_end(input logic [15:0] exp);
        comparisons++;
        if (host.got_rsp !== 1'b1 || host.last_end !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t end %h expected %h", $time,
                     host.last_end, exp);
        end
    endtask : chk_end
    // Write and judge the end code
    task automatic w(input logic [7:0] u, dn, input logic [31:0] d,
                     input logic [15:0] e);
        host.put(u, dn, d);
        chk_end(e);
    endtask : w
    wire [2:0] act = {timing_active, reset_active, laser_off_active};
    // Standard mode: pins drive, commands refused
    task automatic t_std;
        int n_zero;
        int n_cancel;
        n_zero = 0;
        n_cancel = 0;
        chk({bank_mode, focus_mode_on, input_modes}, 0);
        pin_inputs = 5'h03;
        repeat (20) @(negedge clock);
        chk(act, 3'b110);
        for (int i = 0; i < 5; i++)
            w(8'hf0, 8'hc0 + 8'(i), EIC_VAL_ON, ER);
        chk(act, 3'b110);
        // Rising zero and cancel lines give one pulse each
        pin_inputs = 5'h1b;
        repeat (10)
        begin
            @(negedge clock);
            n_zero   += int'(zero_reset_pulse);
            n_cancel += int'(zero_cancel_pulse);
        end
        chk(n_zero, 32'h1);
        chk(n_cancel, 32'h1);
    endtask : t_std
    // Held commands in parallel-input-off mode
    task automatic t_hold;
        w(8'hf0, EIC_DN_EXT_MODE, EIC_MODE_PAR_OFF, OK);
        pin_inputs = 5'h04;
        for (int i = 0; i < 3; i++)
            w(8'hf0, 8'hc0 + 8'(i), EIC_VAL_ON, OK);
        w(8'hf0, 8'hc0, 32'h0000_0002, ER);
        repeat (20) @(negedge clock);
        chk(act, 3'b111);
        w(8'hf0, 8'hc1, 32'h0, OK);
        @(negedge clock);
        chk(act, 3'b101);
        w(8'hf0, EIC_DN_EXT_MODE, EIC_MODE_STANDARD, OK);
        repeat (15) @(negedge clock);
        chk(act, 3'b001);
        pin_inputs = 5'h00;
    endtask : t_hold
    // Zero reset execute and cancel sequence
    task automatic t_zero;
        w(8'hf0, EIC_DN_EXT_MODE, EIC_MODE_PAR_OFF, OK);
        w(8'hf0, EIC_DN_ZERO_EXECUTE, EIC_VAL_ON, OK);
        chk({zero_reset_pulse, zero_cancel_pulse}, 2'b10);
        w(8'hf0, EIC_DN_ZERO_CANCEL, EIC_VAL_ON, OK);
        chk({zero_reset_pulse, zero_cancel_pulse}, 2'b01);
        w(8'hf0, EIC_DN_ZERO_EXECUTE, 32'h0, ER);
        chk({zero_reset_pulse, zero_cancel_pulse}, 2'b00);
        w(8'hf0, EIC_DN_EXT_MODE, EIC_MODE_STANDARD, OK);
    endtask : t_zero
    // Bank mode locks the input 0 mode
    task automatic t_bank;
        w(8'h7f, 8'h0c, 32'h3, OK);
        w(8'h7f, 8'h0d, 32'h5, ER);
        w(8'h7f, 8'h0d, EIC_IN_MODE_MAX, OK);
        w(8'h7f, EIC_DN_FUNC_MODE, EIC_VAL_ON, OK);
        w(8'h7f, 8'h0a, 32'h2, ER);
        chk({bank_mode, input_modes}, {1'b1, 12'h8c0});
        w(8'h7f, EIC_DN_FUNC_MODE, 32'h0, OK);
        w(8'h7f, 8'h0a, 32'h1, OK);
    endtask : t_bank
    // Focus values need focus mode on
    task automatic t_focus;
        w(8'h7a, 8'h05, 32'd10, ER);
        w(8'h7a, EIC_DN_FOCUS_MODE, EIC_VAL_ON, OK);
        w(8'h7a, 8'h05, 32'd20, OK);
        w(8'h7a, 8'h05, 32'd21, ER);
        w(8'h7a, 8'h07, 32'hffff_fff6, OK);
        focus_rd_index = 3'h2;
        repeat (2) @(negedge clock);
        chk(focus_rd_data, 32'd20);
        focus_rd_index = 3'h4;
        repeat (2) @(negedge clock);
        chk(focus_rd_data, 32'hffff_fff6);
        chk(focus_mode_on, 1'b1);
    endtask : t_focus
    // Malformed frames answered with the error code
    task automatic t_frame;
        host.send(16'h0201, 16'hc008, 16'hf001, EIC_ONE_ELEMENT, 32'h2);
        chk_end(ER);
        chk(rsp_code, 16'h0201);
        host.send(EIC_WRITE_CODE, 16'hc008, 16'hf001, 16'h8002, 32'h2);
        chk_end(ER);
        host.send(EIC_WRITE_CODE, 16'hd008, 16'hf001, EIC_ONE_ELEMENT, 32'h2);
        chk_end(ER);
        chk(rsp_code, EIC_WRITE_CODE);
    endtask : t_frame
    // Verdict and end of run
    task automatic summarize;
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_std();
        t_hold();
        t_zero();
        t_bank();
        t_focus();
        t_frame();
        summarize();
    end
    // Watchdog
    initial
    begin
        #20us;
        n_mismatch++;
        summarize();
    end
endmodule : tb
bind eic_external_input_command_control eic_props u_props (.clock, .reset,
    .wr_valid, .wr_code, .wr_addr, .wr_unit_ch, .wr_count, .wr_data,
    .pin_inputs, .rsp_valid, .rsp_code, .rsp_end, .timing_active,
    .reset_active, .zero_reset_pulse, .bank_mode, .focus_mode_on);

// ===== src/eic_external_input_command_control.sv
// External input command control: parameter write port and input mixing
// Functional notes
// - Timing, reset, laser-off command values hold ON until OFF written.
// - Held ON command behaves as the matching physical input held active.
// - Execute write 1 issues zero reset; cancel write 1 cancels it.
// - Standard mode keeps physical inputs and refuses input commands.
// - Back in standard mode, operation follows physical input lines.
// - Bank mode makes inputs 0 and 1 bank select; their modes locked.
// - Focus values accepted only while monitor focus mode is ON.
// - Good write answers echoed code with normal end code zero.
module eic_external_input_command_control
    import eic_pkg::*;
(
    input  wire logic        clock,              // 200 MHz clock
    input  wire logic        reset,              // Async reset, high
    input  wire logic        wr_valid,           // Frame present, pulse
    input  wire logic [15:0] wr_code,            // Command code
    input  wire logic [15:0] wr_addr,            // Prefix plus data number
    input  wire logic [15:0] wr_unit_ch,         // Unit high, channel low
    input  wire logic [15:0] wr_count,           // Prefix plus elements
    input  wire logic [31:0] wr_data,            // Value to write
    input  wire logic [EIC_LINES-1:0] pin_inputs, // Physical input lines
    input  wire logic [2:0]  focus_rd_index,     // Focus word to show
    output logic             rsp_valid,          // Answer pulse
    output logic [15:0]      rsp_code,           // Echoed command code
    output logic [15:0]      rsp_end,            // End code
    output logic             timing_active,      // Effective timing input
    output logic             reset_active,       // Effective reset input
    output logic             laser_off_active,   // Effective laser off
    output logic             zero_reset_pulse,   // Zero reset, one cycle
    output logic             zero_cancel_pulse,  // Zero cancel, one cycle
    output logic             bank_mode,          // Inputs 0/1 select bank
    output logic             focus_mode_on,      // Monitor focus mode
    output logic [EIC_IN_COUNT*EIC_IN_MODE_W-1:0] input_modes, // Modes
    output logic [31:0]      focus_rd_data       // Selected focus word
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [EIC_LINES-1:0] sync1_reg;
    logic [EIC_LINES-1:0] sync2_reg;
    logic [EIC_LINES-1:0] sync3_reg;
    logic [EIC_LINES-1:0] pin_filt_reg;
    logic [EIC_LINES-1:0] pin_filt_next;

    // A change counts once the second and third stage agree
    assign pin_filt_next = (sync2_reg & sync3_reg)
                         | (pin_filt_reg & (sync2_reg | sync3_reg));

    // Three stage chain and agreement filter
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            sync3_reg    <= '0;
            pin_filt_reg <= '0;
        end
        else
        begin
            sync1_reg    <= pin_inputs;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            pin_filt_reg <= pin_filt_next;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    logic [7:0]  unit_no;
    logic [7:0]  data_no;
    logic        frame_ok;
    logic        is_sys;
    logic        is_inp;
    logic        is_foc;
    logic        val_bool;
    logic        val_one;
    logic        par_off_reg;
    logic        bank_reg;
    logic        focus_on_reg;
    logic [2:0]  focus_idx;
    logic        focus_range_ok;
    logic        hit_mode;
    logic        hit_hold;
    logic        hit_zero;
    logic        hit_func;
    logic        hit_inmode;
    logic        hit_fmode;
    logic        hit_fval;
    logic        inmode_locked;
    logic        accept;
    logic [1:0]  hold_sel;
    logic [1:0]  inmode_sel;
    int          sval;

    assign unit_no   = wr_unit_ch[15:8];
    assign data_no   = wr_addr[7:0];
    assign sval      = int'($signed(wr_data));
    // Frame layout check
    assign frame_ok  = (wr_code == EIC_WRITE_CODE)
                     && (wr_addr[15:8] == EIC_ADDR_PREFIX)
                     && (wr_count == EIC_ONE_ELEMENT);
    assign is_sys    = frame_ok && (unit_no == EIC_UNIT_SYSTEM);
    assign is_inp    = frame_ok && (unit_no == EIC_UNIT_INPUTS);
    assign is_foc    = frame_ok && (unit_no == EIC_UNIT_FOCUS);
    assign val_bool  = (wr_data == EIC_VAL_ON) || (wr_data == '0);
    assign val_one   = (wr_data == EIC_VAL_ON);

    // Address hits, each with its own acceptance condition
    assign hit_mode   = is_sys && (data_no == EIC_DN_EXT_MODE);
    assign hit_hold   = is_sys && (data_no >= EIC_DN_TIMING)
                               && (data_no <= EIC_DN_LASER_OFF);
    assign hit_zero   = is_sys && ((data_no == EIC_DN_ZERO_EXECUTE)
                               || (data_no == EIC_DN_ZERO_CANCEL));
    assign hit_func   = is_inp && (data_no == EIC_DN_FUNC_MODE);
    assign hit_inmode = is_inp && (data_no >= EIC_DN_IN0_MODE)
                               && (data_no <= EIC_DN_IN3_MODE);
    assign hit_fmode  = is_foc && (data_no == EIC_DN_FOCUS_MODE);
    assign hit_fval   = is_foc && (data_no >= EIC_DN_FOCUS_FIRST)
                               && (data_no <= EIC_DN_FOCUS_LAST);
    assign hold_sel   = data_no[1:0];
    assign inmode_sel = 2'(data_no - EIC_DN_IN0_MODE);
    assign focus_idx  = 3'(data_no - EIC_DN_FOCUS_FIRST);
    // Inputs 0 and 1 carry bank select in bank mode
    assign inmode_locked = bank_reg && (inmode_sel[1] == 1'b0);

    // Signed range of each focus word
    always_comb
    begin
        unique case (focus_idx)
            3'h0:    focus_range_ok = (sval >= -EIC_DIST1_LIM)
                                   && (sval <= EIC_DIST1_LIM);
            3'h1:    focus_range_ok = (sval >= -EIC_DIST2_LIM)
                                   && (sval <= EIC_DIST2_LIM);
            3'h2,
            3'h3:    focus_range_ok = (sval >= EIC_CUR_MIN)
                                   && (sval <= EIC_CUR_MAX);
            3'h4,
            3'h5:    focus_range_ok = (sval >= -EIC_VOLT_LIM)
                                   && (sval <= EIC_VOLT_LIM);
            default: focus_range_ok = 1'b0;
        endcase
    end

    // Overall acceptance; anything else ends in error
    assign accept =
          (hit_mode && ((wr_data == EIC_MODE_STANDARD)
                     || (wr_data == EIC_MODE_PAR_OFF)))
        || (hit_hold && par_off_reg && val_bool)
        || (hit_zero && par_off_reg && val_one)
        || (hit_func && val_bool)
        || (hit_inmode && !inmode_locked
                       && (wr_data <= EIC_IN_MODE_MAX))
        || (hit_fmode && val_bool)
        || (hit_fval && focus_on_reg && focus_range_ok);

    // ------------------------------------------------------------------
    // Parameter state
    // ------------------------------------------------------------------
    logic [2:0]  hold_cmd_reg;
    logic [EIC_IN_COUNT*EIC_IN_MODE_W-1:0] inmode_reg;
    logic [31:0] focus_mem [EIC_FOCUS_WORDS];
    logic        wr_ok;

    assign wr_ok = wr_valid && accept;

    // Mode, function and focus flags
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            par_off_reg  <= 1'b0;
            bank_reg     <= 1'b0;
            focus_on_reg <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (hit_mode)
                par_off_reg <= (wr_data == EIC_MODE_PAR_OFF);
            if (hit_func)
                bank_reg <= wr_data[0];
            if (hit_fmode)
                focus_on_reg <= wr_data[0];
        end
    end

    // Held command values, kept until OFF is written
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            hold_cmd_reg <= '0;
        else if (wr_ok && hit_hold)
            hold_cmd_reg[hold_sel] <= wr_data[0];
    end

    // Per input mode settings
    generate
        for (genvar i = 0; i < EIC_IN_COUNT; i++)
        begin : g_inmode
            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                    inmode_reg[i*EIC_IN_MODE_W +: EIC_IN_MODE_W] <= '0;
                else if (wr_ok && hit_inmode && (inmode_sel == 2'(i)))
                    inmode_reg[i*EIC_IN_MODE_W +: EIC_IN_MODE_W] <=
                        wr_data[EIC_IN_MODE_W-1:0];
            end
        end
    endgenerate

    // Focus value store
    always_ff @(posedge clock)
    begin
        if (wr_ok && hit_fval)
            focus_mem[focus_idx] <= wr_data;
    end

    // ------------------------------------------------------------------
    // Effective inputs and zero reset events
    // ------------------------------------------------------------------
    logic [2:0]  eff_hold;
    logic        pin_zero_rise;
    logic        pin_cancel_rise;
    logic        zero_next;
    logic        cancel_next;
    logic        pin_zero_old_reg;
    logic        pin_cancel_old_reg;

    // Standard mode follows the lines, otherwise the held commands
    assign eff_hold = par_off_reg ? hold_cmd_reg
                                  : pin_filt_reg[2:0];
    assign pin_zero_rise   = pin_filt_reg[EIC_B_ZERO_EXEC]
                           && !pin_zero_old_reg;
    assign pin_cancel_rise = pin_filt_reg[EIC_B_ZERO_CANCEL]
                           && !pin_cancel_old_reg;
    // Command events only in parallel off; pin edges only in standard
    assign zero_next   = (wr_ok && hit_zero
                         && (data_no == EIC_DN_ZERO_EXECUTE))
                       || (!par_off_reg && pin_zero_rise);
    assign cancel_next = (wr_ok && hit_zero
                         && (data_no == EIC_DN_ZERO_CANCEL))
                       || (!par_off_reg && pin_cancel_rise);

    // Registered outputs and answer
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pin_zero_old_reg   <= 1'b0;
            pin_cancel_old_reg <= 1'b0;
            timing_active      <= 1'b0;
            reset_active       <= 1'b0;
            laser_off_active   <= 1'b0;
            zero_reset_pulse   <= 1'b0;
            zero_cancel_pulse  <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_code           <= '0;
            rsp_end            <= '0;
            bank_mode          <= 1'b0;
            focus_mode_on      <= 1'b0;
            input_modes        <= '0;
            focus_rd_data      <= '0;
        end
        else
        begin
            pin_zero_old_reg   <= pin_filt_reg[EIC_B_ZERO_EXEC];
            pin_cancel_old_reg <= pin_filt_reg[EIC_B_ZERO_CANCEL];
            timing_active      <= eff_hold[EIC_B_TIMING];
            reset_active       <= eff_hold[EIC_B_RESET];
            laser_off_active   <= eff_hold[EIC_B_LASER_OFF];
            zero_reset_pulse   <= zero_next;
            zero_cancel_pulse  <= cancel_next;
            rsp_valid          <= wr_valid;
            if (wr_valid)
            begin
                rsp_code <= wr_code;
                rsp_end  <= accept ? EIC_END_NORMAL
                                   : EIC_END_ERROR;
            end
            bank_mode          <= bank_reg;
            focus_mode_on      <= focus_on_reg;
            input_modes        <= inmode_reg;
            focus_rd_data      <= (focus_rd_index < 3'(EIC_FOCUS_WORDS))
                                ? focus_mem[focus_rd_index] : '0;
        end
    end

endmodule : eic_external_input_command_control

// ===== src/eic_pkg.sv
// Constants shared by the external input command block
package eic_pkg;
    // ------------------------------------------------------------------
    // Frame fields
    // ------------------------------------------------------------------
    localparam logic [15:0] EIC_WRITE_CODE   = 16'h0202;
    localparam logic [7:0]  EIC_ADDR_PREFIX  = 8'hc0;
    localparam logic [15:0] EIC_ONE_ELEMENT  = 16'h8001;
    localparam logic [15:0] EIC_END_NORMAL   = 16'h0000;
    // Error end code, value arbitrary
    localparam logic [15:0] EIC_END_ERROR    = 16'h1100;

    // ------------------------------------------------------------------
    // Unit numbers
    // ------------------------------------------------------------------
    localparam logic [7:0]  EIC_UNIT_SYSTEM  = 8'hf0;
    localparam logic [7:0]  EIC_UNIT_INPUTS  = 8'h7f;
    localparam logic [7:0]  EIC_UNIT_FOCUS   = 8'h7a;

    // ------------------------------------------------------------------
    // Data numbers
    // ------------------------------------------------------------------
    localparam logic [7:0]  EIC_DN_EXT_MODE      = 8'h08;
    localparam logic [7:0]  EIC_DN_TIMING        = 8'hc0;
    localparam logic [7:0]  EIC_DN_RESET         = 8'hc1;
    localparam logic [7:0]  EIC_DN_LASER_OFF     = 8'hc2;
    localparam logic [7:0]  EIC_DN_ZERO_EXECUTE  = 8'hc3;
    localparam logic [7:0]  EIC_DN_ZERO_CANCEL   = 8'hc4;
    localparam logic [7:0]  EIC_DN_FUNC_MODE     = 8'h01;
    localparam logic [7:0]  EIC_DN_IN0_MODE      = 8'h0a;
    localparam logic [7:0]  EIC_DN_IN3_MODE      = 8'h0d;
    localparam logic [7:0]  EIC_DN_FOCUS_MODE    = 8'h02;
    localparam logic [7:0]  EIC_DN_FOCUS_FIRST   = 8'h03;
    localparam logic [7:0]  EIC_DN_FOCUS_LAST    = 8'h08;

    // ------------------------------------------------------------------
    // Values and ranges
    // ------------------------------------------------------------------
    localparam logic [31:0] EIC_MODE_STANDARD    = 32'h0000_0000;
    localparam logic [31:0] EIC_MODE_PAR_OFF     = 32'h0000_0002;
    localparam logic [31:0] EIC_VAL_ON           = 32'h0000_0001;
    localparam logic [31:0] EIC_IN_MODE_MAX      = 32'h0000_0004;
    localparam int          EIC_DIST1_LIM        = 99999999;
    localparam int          EIC_DIST2_LIM        = 999999999;
    localparam int          EIC_CUR_MIN          = 4;
    localparam int          EIC_CUR_MAX          = 20;
    localparam int          EIC_VOLT_LIM         = 10;
    localparam int          EIC_FOCUS_WORDS      = 6;
    localparam int          EIC_IN_COUNT         = 4;
    localparam int          EIC_IN_MODE_W        = 3;

    // Bit positions of the five input lines
    localparam int          EIC_B_TIMING         = 0;
    localparam int          EIC_B_RESET          = 1;
    localparam int          EIC_B_LASER_OFF      = 2;
    localparam int          EIC_B_ZERO_EXEC      = 3;
    localparam int          EIC_B_ZERO_CANCEL    = 4;
    localparam int          EIC_LINES            = 5;
endpackage : eic_pkg
